// *** src/busc_pkg.sv ***
// Constants shared by the bus unit status and counter block.
// Assumes an 8-bit register port and a bit engine on the same clock.
package busc_pkg;
  localparam int AW = 32;
  localparam int DW = 8;
  // Register addresses
  localparam logic [AW-1:0] ADDR_ISR = 32'h0ffff3f0;
  localparam logic [AW-1:0] ADDR_SSR = 32'hfffff3f2;
  localparam logic [AW-1:0] ADDR_SCR = 32'hfffff3f4;
  localparam logic [AW-1:0] ADDR_CCR = 32'h0ffff3f6;
  localparam logic [AW-1:0] ADDR_CKS = 32'hfffff3f8;
  localparam logic [AW-1:0] ADDR_BCR = 32'hfffff3fa;
  localparam logic [AW-1:0] ADDR_DR = 32'hfffff3fc;
  localparam logic [AW-1:0] ADDR_DLR = 32'hfffff3fe;
  // Interrupt status bit positions
  localparam int ISR_ERR = 6;
  localparam int ISR_START = 5;
  localparam int ISR_STATUS = 4;
  localparam int ISR_CEND = 3;
  localparam int ISR_FEND = 2;
  // Bus control bit positions
  localparam int BCR_MREQ = 6;
  localparam int BCR_STX = 4;
  localparam int BCR_SRX = 3;
  // Slave status layout
  localparam logic [1:0] SSR_MODE = 2'h1;
  localparam logic [7:0] SSR_RST = 8'h41;
  // Counter presets
  localparam logic [7:0] FRAME_MAX = 8'h20;
  localparam logic [7:0] STATUS_LEN = 8'h01;
  localparam logic [1:0] OVR_TX_MAX = 2'h2;
  // Bit width limits in timer ticks, per clock select value
  localparam logic [7:0] TW_MIN_LO = 8'h10;
  localparam logic [7:0] TW_MAX_LO = 8'h60;
  localparam logic [7:0] TW_MIN_HI = 8'h20;
  localparam logic [7:0] TW_MAX_HI = 8'hc0;
endpackage : busc_pkg

// *** src/busc_status.sv ***
// Status flags, error detection and byte counters of the serial bus unit.
// Assumes a bit engine on i_core_clk giving one-cycle event pulses.
// Overview of operation
// - Communication-end flag sets when success count hits zero; cleared by control bit set.
// - Frame-end flag sets when frame count hits zero; same clear.
// - Eight-bit timer flags bit width outside limits as error.
// - Parity error flags error except data field in individual mode.
// - No parity error interrupt when slave request lost to broadcast.
// - Negative acknowledge in non-data fields errors in individual mode only.
// - Missing next transmit byte at acknowledge flags underrun.
// - Individual overrun withholds acknowledge; frame count drops, success count not.
// - Broadcast overrun stops reception, errors, leaves data register alone.
// - Overrun releases only on data register read or reset.
// - Frame end still raised while overrun held.
// - In overrun no data update; unaddressed traffic raises nothing.
// - Transmission in overrun limited to two bytes, ends in underrun.
// - Slave status reads 41H at reset when unlocked, 45H when locked; mode, enable, lock, held bits.
// - Slave status transmission uses length one set by hardware.
// - Success counter loads length, decrements on data acknowledge.
// - Success counter is nine bits, low eight readable.
// - Frame counter resets to 20H, decrements per byte.
// - Clock select bit picks slow or fast bus timing.
// - Writing zero to end flags does not clear them.
// - Master request bit 6, slave transmit 4, slave receive 3.
module busc_status (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [busc_pkg::AW-1:0] i_addr,
  input wire logic [busc_pkg::DW-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [busc_pkg::DW-1:0] o_rdata,
  input wire logic i_bus_rx,
  input wire logic i_bit_check_en,
  input wire logic i_comm_start,
  input wire logic i_status_tx,
  input wire logic i_broadcast,
  input wire logic i_receiving,
  input wire logic i_addressed,
  input wire logic i_data_field,
  input wire logic i_byte_done,
  input wire logic i_data_ack,
  input wire logic i_rx_byte_valid,
  input wire logic [busc_pkg::DW-1:0] i_rx_byte,
  input wire logic i_parity_err,
  input wire logic i_nack_rx,
  input wire logic i_arb_lost_bcast,
  input wire logic i_start_evt,
  input wire logic i_status_evt,
  input wire logic i_locked,
  input wire logic i_tx_take,
  output logic [busc_pkg::DW-1:0] o_tx_byte,
  output logic o_ack_enable,
  output logic o_rx_stop,
  output logic o_tx_stop,
  output logic o_clock_select,
  output logic o_data_request_irq,
  output logic o_error_status_irq
);
  import busc_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] dr;
    logic [7:0] message_length_register;
    logic [7:0] bcr;
    logic cks;
    logic err;
    logic start;
    logic status;
    logic cend;
    logic fend;
    logic [8:0] scnt;
    logic [7:0] fcnt;
    logic rx_held;
    logic tx_held;
    logic ovr;
    logic [1:0] otx;
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [7:0] tmr;
    logic ack_en;
    logic rx_stop;
    logic tx_stop;
    logic dirq;
    logic eirq;
  } busc_st_t;

  localparam busc_st_t RST_ST = '{
    rdata: 8'h00, dr: 8'h00, message_length_register: 8'h00, bcr: 8'h00, cks: 1'b0,
    err: 1'b0, start: 1'b0, status: 1'b0, cend: 1'b0, fend: 1'b0,
    scnt: 9'h000, fcnt: FRAME_MAX, rx_held: SSR_RST[1], tx_held: SSR_RST[0],
    ovr: 1'b0, otx: 2'h0, s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1,
    tmr: 8'h00, ack_en: 1'b1, rx_stop: 1'b0, tx_stop: 1'b0, dirq: 1'b0, eirq: 1'b0};

  busc_st_t st_ff;
  busc_st_t nxt_st;

  logic wr_isr;
  logic wr_bcr;
  logic ctl_set;
  logic dr_read;
  logic held_eff;
  logic edge_seen;
  logic [7:0] tw_min;
  logic [7:0] tw_max;
  logic [8:0] len_load;
  logic [7:0] ssr_val;

  always_comb begin
    nxt_st = st_ff;
    wr_isr = i_we && (i_addr == ADDR_ISR);
    wr_bcr = i_we && (i_addr == ADDR_BCR);
    ctl_set = wr_bcr && (i_wdata[BCR_MREQ] || i_wdata[BCR_STX] || i_wdata[BCR_SRX]);
    dr_read = i_re && (i_addr == ADDR_DR);
    held_eff = st_ff.rx_held && !dr_read;
    tw_min = st_ff.cks ? TW_MIN_HI : TW_MIN_LO;
    tw_max = st_ff.cks ? TW_MAX_HI : TW_MAX_LO;
    len_load = (st_ff.message_length_register == 8'h00) ? 9'h100 : {1'b0, st_ff.message_length_register};
    if (i_status_tx) begin
      len_load = {1'b0, STATUS_LEN};
    end
    ssr_val = {SSR_MODE, 1'b0, st_ff.bcr[BCR_STX], 1'b0, i_locked, st_ff.rx_held, st_ff.tx_held};

    // Register writes
    if (wr_bcr) begin
      nxt_st.bcr = i_wdata;
    end
    if (i_we && (i_addr == ADDR_CKS)) begin
      nxt_st.cks = i_wdata[0];
    end
    if (i_we && (i_addr == ADDR_DLR)) begin
      nxt_st.message_length_register = i_wdata;
    end
    if (i_we && (i_addr == ADDR_DR)) begin
      nxt_st.dr = i_wdata;
      nxt_st.tx_held = 1'b1;
    end
    if (i_tx_take) begin
      nxt_st.tx_held = 1'b0;
    end
    // Any byte write clears the software-cleared flags; sets below win
    if (wr_isr) begin
      nxt_st.err = 1'b0;
      nxt_st.start = 1'b0;
      nxt_st.status = 1'b0;
    end
    // End flags ignore the status write and clear only on a control bit set
    if (ctl_set) begin
      nxt_st.cend = 1'b0;
      nxt_st.fend = 1'b0;
    end
    if (i_start_evt) begin
      nxt_st.start = 1'b1;
    end
    if (i_status_evt) begin
      nxt_st.status = 1'b1;
    end

    // Overrun release on data register read
    if (dr_read) begin
      nxt_st.rx_held = 1'b0;
      nxt_st.ovr = 1'b0;
    end

    // Counters
    if (i_comm_start) begin
      nxt_st.scnt = len_load;
      nxt_st.fcnt = FRAME_MAX;
      nxt_st.otx = 2'h0;
    end else begin
      if (i_data_ack && i_data_field && (st_ff.scnt != 9'h000) && !(i_receiving && st_ff.ovr)) begin
        nxt_st.scnt = st_ff.scnt - 9'h001;
        if (st_ff.scnt == 9'h001) begin
          nxt_st.cend = 1'b1;
        end
      end
      if (i_byte_done && (st_ff.fcnt != 8'h00)) begin
        nxt_st.fcnt = st_ff.fcnt - 8'h01;
        if (st_ff.fcnt == 8'h01) begin
          nxt_st.fend = 1'b1;
        end
      end
      if (i_byte_done && !i_receiving && st_ff.ovr && (st_ff.otx != OVR_TX_MAX)) begin
        nxt_st.otx = st_ff.otx + 2'h1;
      end
    end

    // Reception and overrun
    nxt_st.rx_stop = 1'b0;
    if (i_rx_byte_valid && i_addressed) begin
      if (held_eff || st_ff.ovr) begin
        nxt_st.ovr = 1'b1;
        nxt_st.rx_held = 1'b1;
        if (i_broadcast) begin
          nxt_st.err = 1'b1;
          nxt_st.rx_stop = 1'b1;
        end
      end else begin
        nxt_st.dr = i_rx_byte;
        nxt_st.rx_held = 1'b1;
      end
    end

    // Error triggers
    if (i_parity_err && (!i_data_field || i_broadcast) && !i_arb_lost_bcast) begin
      nxt_st.err = 1'b1;
    end
    if (i_nack_rx && !i_data_field && !i_broadcast) begin
      nxt_st.err = 1'b1;
    end
    if (i_data_ack && i_data_field && !i_receiving && !st_ff.tx_held && (st_ff.scnt > 9'h001)) begin
      nxt_st.err = 1'b1;
    end

    // Bit width timer on the synchronised line
    nxt_st.s1 = i_bus_rx;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    edge_seen = (st_ff.s2 == st_ff.s3) && (st_ff.s2 != st_ff.lvl);
    if (edge_seen) begin
      nxt_st.lvl = st_ff.s2;
    end
    if (!i_bit_check_en) begin
      nxt_st.tmr = 8'h00;
    end else if (edge_seen) begin
      nxt_st.tmr = 8'h00;
      if (st_ff.tmr < tw_min) begin
        nxt_st.err = 1'b1;
      end
    end else if (st_ff.tmr != tw_max) begin
      nxt_st.tmr = st_ff.tmr + 8'h01;
      if (st_ff.tmr == (tw_max - 8'h01)) begin
        nxt_st.err = 1'b1;
      end
    end

    // Read port: data valid only in the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (i_re) begin
      case (i_addr)
        ADDR_ISR: nxt_st.rdata = {1'b0, st_ff.err, st_ff.start, st_ff.status, st_ff.cend, st_ff.fend, 2'b00};
        ADDR_SSR: nxt_st.rdata = ssr_val;
        ADDR_SCR: nxt_st.rdata = st_ff.scnt[7:0];
        ADDR_CCR: nxt_st.rdata = st_ff.fcnt;
        ADDR_CKS: nxt_st.rdata = {7'h00, st_ff.cks};
        ADDR_BCR: nxt_st.rdata = st_ff.bcr;
        ADDR_DR: nxt_st.rdata = st_ff.dr;
        ADDR_DLR: nxt_st.rdata = st_ff.message_length_register;
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // Outputs
    nxt_st.ack_en = !nxt_st.ovr;
    nxt_st.tx_stop = nxt_st.ovr && (nxt_st.otx == OVR_TX_MAX);
    // No write request while in overrun, so software cannot refill and underrun follows
    nxt_st.dirq = nxt_st.rx_held || (!i_receiving && i_data_field && !nxt_st.tx_held && !nxt_st.ovr);
    nxt_st.eirq = nxt_st.err || nxt_st.start || nxt_st.status || nxt_st.cend || nxt_st.fend;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= RST_ST;
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_tx_byte = st_ff.dr;
  assign o_ack_enable = st_ff.ack_en;
  assign o_rx_stop = st_ff.rx_stop;
  assign o_tx_stop = st_ff.tx_stop;
  assign o_clock_select = st_ff.cks;
  assign o_data_request_irq = st_ff.dirq;
  assign o_error_status_irq = st_ff.eirq;
endmodule : busc_status

// *** tb/busc_line_model.sv ***
// Far unit model driving the shared bus line.
// Assumes a pulled-up line that idles high between bits.
module busc_line_model (
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic [7:0] i_width,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_line = 1'b1;
  // Low phase of i_width cycles; short values make a bad bit
  always @(posedge i_core_clk) begin
    if (i_go) begin
      o_line <= 1'b0;
      repeat (i_width) @(posedge i_core_clk);
      o_line <= 1'b1;
    end
  end
endmodule : busc_line_model

// *** tb/busc_status_properties.sv ***
// Port checker of the status block.
// Assumes one clock; reset disables all.
module busc_status_chk (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [busc_pkg::AW-1:0] i_addr,
  input wire logic [busc_pkg::DW-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [busc_pkg::DW-1:0] o_rdata,
  input wire logic i_comm_start,
  input wire logic i_status_tx,
  input wire logic i_data_ack,
  input wire logic i_data_field,
  input wire logic i_locked,
  input wire logic o_ack_enable,
  input wire logic o_rx_stop,
  input wire logic o_tx_stop,
  input wire logic o_clock_select,
  input wire logic o_error_status_irq
);
  import busc_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence status_go;
    i_comm_start && i_status_tx && i_clk_en;
  endsequence
  sequence data_acked;
    i_data_ack && i_data_field && i_clk_en;
  endsequence
  chk_ssr_fixed: assert property (i_re && i_clk_en && i_addr == ADDR_SSR |=>
    o_rdata[7:5] == 3'h2 && !o_rdata[3] && o_rdata[2] == $past(i_locked)) else $error("slave status wrong");
  chk_clk_select: assert property (i_we && i_clk_en && i_addr == ADDR_CKS |=>
    o_clock_select == $past(i_wdata[0])) else $error("clock select wrong");
  chk_status_len: assert property (status_go ##[1:8] data_acked |=>
    ##[0:1] o_error_status_irq) else $error("status length not one");
  chk_bcast_err: assert property (o_rx_stop |-> ##[0:1] o_error_status_irq)
    else $error("broadcast overrun without error");
  chk_stop_ack: assert property (o_rx_stop |-> ##[0:1] !o_ack_enable)
    else $error("overrun without ack hold");
  // Ack low marks the overrun state
  chk_ovr_hold: assert property (!o_ack_enable && !(i_re && i_addr == ADDR_DR) |=> !o_ack_enable)
    else $error("overrun left without read");
  chk_ovr_release: assert property (i_re && i_clk_en && i_addr == ADDR_DR |-> ##[1:2] o_ack_enable)
    else $error("overrun kept after read");
  chk_tx_limit: assert property (o_tx_stop |-> !o_ack_enable)
    else $error("tx stop outside overrun");
endmodule : busc_status_chk
bind busc_status busc_status_chk chk_u (.*);

// *** tb/busc_status_tb_top.sv ***
// Self-checking bench of the status and counter block.
// Assumes the line model as far unit, 100 MHz clock.
module busc_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import busc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, re = 1'b0, we = 1'b0, lk = 1'b0, bc = 1'b0;
  logic rx = 1'b0, ad = 1'b0, df = 1'b0, st = 1'b0, go = 1'b0, tm = 1'b0, nk = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [AW-1:0] a = 32'h0;
  logic [DW-1:0] d = 8'h00, b = 8'h00, rdata;
  logic line, ack, rstop, tstop, cs, dirq, eirq;
  logic [7:0] cb [3] = '{8'h40, 8'h10, 8'h08};
  logic [3:0] pt [4] = '{4'h1, 4'h4, 4'hd, 4'ha};
  int fails = 0, samples_checked = 0, n = 0, cyc = 0;
  always #5 clk = ~clk;
  busc_line_model pm_u (.i_core_clk(clk), .i_go(go), .i_width(8'h04), .o_line(line));
  busc_status dut_u (.i_core_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_addr(a), .i_wdata(d),
    .i_we(we), .i_re(re), .o_rdata(rdata), .i_bus_rx(line), .i_bit_check_en(tm),
    .i_comm_start(ev[0]), .i_status_tx(st), .i_broadcast(bc), .i_receiving(rx),
    .i_addressed(ad), .i_data_field(df), .i_byte_done(ev[1]), .i_data_ack(ev[2]),
    .i_rx_byte_valid(ev[3]), .i_rx_byte(b), .i_parity_err(ev[4]), .i_nack_rx(nk),
    .i_arb_lost_bcast(ev[5]), .i_start_evt(1'b0), .i_status_evt(1'b0), .i_locked(lk),
    .i_tx_take(1'b0), .o_tx_byte(), .o_ack_enable(ack), .o_rx_stop(rstop),
    .o_tx_stop(tstop), .o_clock_select(cs), .o_data_request_irq(dirq),
    .o_error_status_irq(eirq));
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] x, input logic [7:0] v);
    @(posedge clk);
    a <= x;
    d <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] x, input logic [7:0] e, input string s);
    @(posedge clk);
    a <= x;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(s, rdata, e);
  endtask : rd
  task automatic pl(input logic [5:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 6'h00;
  endtask : pl
  task automatic results();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Ceiling well above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h1430aac6));
    lk = 1'($urandom_range(1));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_SSR, {5'h08, lk, 2'h1}, "ssr");
    rd(ADDR_CCR, FRAME_MAX, "ccr");
    rd(32'h0, 8'h00, "gap");
    n = $urandom_range(1);
    wr(ADDR_CKS, 8'(n));
    #1 chk("cks", {7'h0, cs}, 8'(n));
    foreach (cb[k]) begin
      n = $urandom_range(6, 2);
      wr(ADDR_DLR, 8'(n));
      rx <= 1'b1;
      df <= 1'b1;
      ad <= 1'b1;
      pl(6'h01);
      rd(ADDR_SCR, 8'(n), "scr");
      repeat (n) pl(6'h06);
      rd(ADDR_SCR, 8'h00, "scr");
      rd(ADDR_CCR, FRAME_MAX - 8'(n), "ccr");
      wr(ADDR_ISR, 8'h00);
      rd(ADDR_ISR, 8'h08, "isr");
      wr(ADDR_BCR, cb[k]);
      @(posedge clk);
      #1 chk("irq", {7'h0, eirq}, 8'h00);
    end
    wr(ADDR_DLR, 8'h00);
    pl(6'h01);
    pl(6'h06);
    rd(ADDR_SCR, 8'hff, "scr");
    wr(ADDR_DLR, 8'h05);
    st <= 1'b1;
    pl(6'h01);
    st <= 1'b0;
    rd(ADDR_SCR, STATUS_LEN, "scr");
    pl(6'h06);
    wr(ADDR_BCR, 8'h40);
    foreach (pt[k]) begin
      wr(ADDR_ISR, 8'h00);
      bc <= pt[k][3];
      df <= pt[k][2];
      pl({pt[k][1], 5'h10});
      @(posedge clk);
      #1 chk("par", {7'h0, eirq}, {7'h0, pt[k][0]});
    end
    // Negative acknowledge outside the data field, individual mode
    wr(ADDR_ISR, 8'h00);
    bc <= 1'b0;
    df <= 1'b0;
    @(posedge clk);
    nk <= 1'b1;
    @(posedge clk);
    nk <= 1'b0;
    @(posedge clk);
    #1 chk("nack", {7'h0, eirq}, 8'h01);
    wr(ADDR_ISR, 8'h00);
    bc <= 1'b1;
    df <= 1'b1;
    b <= 8'($urandom);
    pl(6'h08);
    b <= ~b;
    pl(6'h08);
    @(posedge clk);
    #1 chk("ack", {7'h0, ack}, 8'h00);
    chk("irq", {7'h0, eirq}, 8'h01);
    rd(ADDR_SSR, {5'h08, lk, 2'h3}, "ssr");
    rd(ADDR_DR, ~b, "dr");
    @(posedge clk);
    #1 chk("ack", {7'h0, ack}, 8'h01);
    wr(ADDR_ISR, 8'h00);
    tm <= 1'b1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (16) @(posedge clk);
    #1 chk("tmr", {7'h0, eirq}, 8'h01);
    results();
  end
endmodule : busc_status_tb_top
